// [fsu_pkg.sv]
// Shared constants and types of the fractional subtract unit.
// Assumes a 32-bit host pipeline and an APB register bus with byte strobes.
package fsu_pkg;

    // ***********************************************************
    // Instruction fields
    // ***********************************************************
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 26;
    localparam int SECOND_MSB = 25;
    localparam int SECOND_LSB = 21;
    localparam int FIRST_MSB = 20;
    localparam int FIRST_LSB = 16;
    localparam int DEST_MSB = 15;
    localparam int DEST_LSB = 11;
    localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;
    localparam logic [9:0] MINOR_WORD_CLAMP = 10'h345;
    localparam logic [10:0] MINOR_PAIR_WRAP = 11'h20D;
    localparam logic [10:0] MINOR_PAIR_CLAMP = 11'h60D;
    localparam logic [10:0] MINOR_HALVE_TRUNC = 11'h24D;
    localparam logic [10:0] MINOR_HALVE_ROUND = 11'h64D;

    // ***********************************************************
    // Register map, field positions and reset values
    // ***********************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DSPCTL = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int OUFLAG_BIT = 20;
    localparam int INT_OUFLAG = 0;
    localparam int INT_RESERVED = 1;
    localparam int INT_DISABLED = 2;
    localparam int INT_WIDTH = 3;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic OUFLAG_RESET = 1'b0;
    localparam logic [INT_WIDTH-1:0] INT_STATUS_RESET = 3'h0;
    localparam logic [INT_WIDTH-1:0] INT_MASK_RESET = 3'h0;

    // ***********************************************************
    // Operations and lane modes
    // ***********************************************************
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PAIR_WRAP = 3'h1,
        OP_PAIR_CLAMP = 3'h3,
        OP_WORD_CLAMP = 3'h2,
        OP_HALVE_TRUNC = 3'h6,
        OP_HALVE_ROUND = 3'h7
    } fsu_op_type;

    typedef enum logic [1:0] {
        MODE_WRAP = 2'h0,
        MODE_CLAMP = 2'h1,
        MODE_TRUNC = 2'h3,
        MODE_ROUND = 2'h2
    } fsu_mode_type;

endpackage : fsu_pkg

// [fsu_lane.sv]
// One signed fractional subtract lane of parameterised width.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module fsu_lane
    import fsu_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic [WIDTH-1:0] minuend,
    input wire logic [WIDTH-1:0] subtrahend,
    input wire fsu_mode_type mode,
    output logic [WIDTH-1:0] diff_out,
    output logic overflow
);

    logic [WIDTH:0] wide;
    logic [WIDTH:0] rounded;
    logic [WIDTH-1:0] limit;

    // One extra sign bit keeps the true difference in range.
    assign wide = {minuend[WIDTH-1], minuend}
                - {subtrahend[WIDTH-1], subtrahend};
    // The rounding add stays inside the interim width and may wrap there.
    assign rounded = wide + {{WIDTH{1'b0}}, 1'b1};
    assign limit = wide[WIDTH] ? {1'b1, {(WIDTH-1){1'b0}}}
                               : {1'b0, {(WIDTH-1){1'b1}}};
    assign overflow = (wide[WIDTH] ^ wide[WIDTH-1])
                    && (mode == MODE_WRAP || mode == MODE_CLAMP);

    always_comb
    begin
        unique case (mode)
            MODE_WRAP: diff_out = wide[WIDTH-1:0];
            MODE_CLAMP: diff_out = overflow ? limit
                                            : wide[WIDTH-1:0];
            MODE_TRUNC: diff_out = wide[WIDTH:1];
            MODE_ROUND: diff_out = rounded[WIDTH:1];
        endcase
    end

endmodule : fsu_lane

// [fsu_decode.sv]
// Instruction decoder of the fractional subtract unit.
// Assumes the word arrives whole; anything else decodes as OP_NONE.
`timescale 1ns/1ps
module fsu_decode
    import fsu_pkg::*;
(
    input wire logic [31:0] instr,
    output fsu_op_type op
);

    logic group_hit;

    assign group_hit = instr[OPC_MSB:OPC_LSB] == MAJOR_OPCODE_GROUP;

    always_comb
    begin
        op = OP_NONE;
        if (group_hit)
        begin
            if (!instr[10] && instr[9:0] == MINOR_WORD_CLAMP)
                op = OP_WORD_CLAMP;
            else if (instr[10:0] == MINOR_PAIR_WRAP)
                op = OP_PAIR_WRAP;
            else if (instr[10:0] == MINOR_PAIR_CLAMP)
                op = OP_PAIR_CLAMP;
            else if (instr[10:0] == MINOR_HALVE_TRUNC)
                op = OP_HALVE_TRUNC;
            else if (instr[10:0] == MINOR_HALVE_ROUND)
                op = OP_HALVE_ROUND;
        end
    end

endmodule : fsu_decode

// [fsu_top.sv]
// Fractional subtract unit with its flag, control and interrupt registers.
// Assumes operands are read by the host pipeline and handed in with the
// instruction, and that the result is written back by the host.
//
// How it works
// - Pair subtract: each source halfword minus the matching one, per lane.
// - Wrapping pair variant keeps the low 16 bits of each difference.
// - Clamping pair variant limits lanes to 0x7FFF or 0x8000.
// - Pair variants set flag bit 20 on any lane overflow, else keep it.
// - Word subtract clamps to 0x7FFFFFFF or 0x80000000 on overflow.
// - Word subtract sets flag bit 20 on overflow, else leaves it.
// - Halving variants form a 17-bit signed difference per lane.
// - Truncating halving writes bits 16 to 1 of each difference.
// - Rounding halving adds one before the one-bit right shift.
// - Halving variants never change the flag register.
// - Operand values never raise an exception.
// - Word subtract decodes from group 000000, minor 1101000101, fields.
// - Unknown codes raise reserved, disabled unit raises disabled.
`timescale 1ns/1ps
module fsu_top
    import fsu_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] first_source,
    input wire logic [31:0] second_source,
    output logic result_valid,
    output logic [31:0] result_data,
    output logic [4:0] result_dest,
    output logic exc_reserved,
    output logic exc_dsp_disabled,
    output logic ouflag,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ***********************************************************
    // State
    // ***********************************************************
    // One packed record holds every register, so reset and update each
    // live in a single place and no field can be missed in either.
    typedef struct packed {
        logic result_valid;
        logic [31:0] result_data;
        logic [4:0] result_dest;
        logic exc_reserved;
        logic exc_disabled;
        logic dsp_enable;
        logic ouflag;
        logic [INT_WIDTH-1:0] int_status;
        logic [INT_WIDTH-1:0] int_mask;
        logic irq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } fsu_state_type;

    // The unit wakes up enabled, so software that never touches the
    // control register can still issue the subtract operations.
    localparam fsu_state_type STATE_RESET = '{
        result_valid: 1'b0,
        result_data: 32'h0000_0000,
        result_dest: 5'h00,
        exc_reserved: 1'b0,
        exc_disabled: 1'b0,
        dsp_enable: CTRL_ENABLE_RESET,
        ouflag: OUFLAG_RESET,
        int_status: INT_STATUS_RESET,
        int_mask: INT_MASK_RESET,
        irq: 1'b0,
        pready: 1'b0,
        prdata: 32'h0000_0000,
        pslverr: 1'b0
    };

    fsu_state_type st;
    fsu_state_type next_st;

    // ***********************************************************
    // Decode and datapath
    // ***********************************************************
    fsu_op_type op;
    fsu_mode_type lane_mode;
    logic [31:0] pair_result;
    logic [1:0] lane_overflow;
    logic [31:0] word_result;
    logic word_overflow;
    logic flag_op;
    logic op_overflow;
    logic [31:0] op_result;

    fsu_decode u_decode (
        .instr(issue_instr),
        .op(op)
    );

    // Word and unknown codes leave the lanes in wrap mode; their lane
    // results are computed but never selected.
    always_comb
    begin
        unique case (op)
            OP_PAIR_CLAMP: lane_mode = MODE_CLAMP;
            OP_HALVE_TRUNC: lane_mode = MODE_TRUNC;
            OP_HALVE_ROUND: lane_mode = MODE_ROUND;
            default: lane_mode = MODE_WRAP;
        endcase
    end

    // Lane 1 covers bits 31 to 16 and lane 0 bits 15 to 0.
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++)
        begin : g_lane
            fsu_lane #(
                .WIDTH(16)
            ) u_lane (
                .minuend(first_source[16*lane +: 16]),
                .subtrahend(second_source[16*lane +: 16]),
                .mode(lane_mode),
                .diff_out(pair_result[16*lane +: 16]),
                .overflow(lane_overflow[lane])
            );
        end
    endgenerate

    // A separate 33-bit adder serves the word operation. Chaining the lane
    // adders would save area but lengthen the carry path.
    fsu_lane #(
        .WIDTH(32)
    ) u_word (
        .minuend(first_source),
        .subtrahend(second_source),
        .mode(MODE_CLAMP),
        .diff_out(word_result),
        .overflow(word_overflow)
    );

    // Only the wrapping and clamping forms report overflow.
    always_comb
    begin
        flag_op = 1'b0;
        op_overflow = 1'b0;
        op_result = pair_result;
        unique case (op)
            OP_PAIR_WRAP, OP_PAIR_CLAMP:
            begin
                flag_op = 1'b1;
                op_overflow = |lane_overflow;
            end
            OP_WORD_CLAMP:
            begin
                flag_op = 1'b1;
                op_overflow = word_overflow;
                op_result = word_result;
            end
            OP_HALVE_TRUNC, OP_HALVE_ROUND:
            begin
                flag_op = 1'b0;
            end
            OP_NONE:
            begin
                flag_op = 1'b0;
            end
        endcase
    end

    // ***********************************************************
    // Register bus
    // ***********************************************************
    logic setup_done;
    logic commit;
    logic addr_known;
    logic [31:0] read_value;
    logic [7:0] reg_addr;

    assign reg_addr = paddr[7:0];
    // One wait state: pready rises the cycle after the access phase starts.
    assign setup_done = psel && penable && !st.pready;
    // A write takes effect only at the edge where the master sees pready
    // high, and never when the address was refused.
    assign commit = psel && penable && st.pready && pwrite && !st.pslverr;

    always_comb
    begin
        addr_known = 1'b1;
        read_value = 32'h0000_0000;
        unique case (reg_addr)
            ADDR_CTRL:
                read_value[CTRL_ENABLE_BIT] = st.dsp_enable;
            ADDR_DSPCTL:
                read_value[OUFLAG_BIT] = st.ouflag;
            ADDR_INT_STATUS:
                read_value[INT_WIDTH-1:0] = st.int_status;
            ADDR_INT_MASK:
                read_value[INT_WIDTH-1:0] = st.int_mask;
            ADDR_RESULT:
                read_value = st.result_data;
            default:
                addr_known = 1'b0;
        endcase
        // Upper address bits must be clear for a hit.
        if (ADDR_WIDTH > 8 && (paddr >> 8) != '0)
        begin
            addr_known = 1'b0;
        end
    end

    // ***********************************************************
    // Next state
    // ***********************************************************
    // Events are gathered apart from the status bits, so an overflow raises
    // its status bit again even while the sticky flag is already set.
    logic [INT_WIDTH-1:0] events;

    always_comb
    begin
        next_st = st;
        events = '0;
        next_st.result_valid = 1'b0;
        next_st.exc_reserved = 1'b0;
        next_st.exc_disabled = 1'b0;

        // Software writes land first so that hardware sets below win.
        if (commit)
        begin
            unique case (reg_addr)
                ADDR_CTRL:
                begin
                    if (pstrb[0])
                        next_st.dsp_enable = pwdata[CTRL_ENABLE_BIT];
                end
                ADDR_DSPCTL:
                begin
                    if (pstrb[2])
                        next_st.ouflag = pwdata[OUFLAG_BIT];
                end
                ADDR_INT_STATUS:
                begin
                    if (pstrb[0])
                        next_st.int_status = st.int_status
                                           & ~pwdata[INT_WIDTH-1:0];
                end
                ADDR_INT_MASK:
                begin
                    if (pstrb[0])
                        next_st.int_mask = pwdata[INT_WIDTH-1:0];
                end
                default:
                begin
                    next_st.ouflag = next_st.ouflag;
                end
            endcase
        end

        // Exceptions depend on the code and the enable, never on operands.
        if (issue_valid)
        begin
            if (op == OP_NONE)
            begin
                next_st.exc_reserved = 1'b1;
                events[INT_RESERVED] = 1'b1;
            end
            else if (!st.dsp_enable)
            begin
                next_st.exc_disabled = 1'b1;
                events[INT_DISABLED] = 1'b1;
            end
            else
            begin
                next_st.result_valid = 1'b1;
                next_st.result_data = op_result;
                next_st.result_dest = issue_instr[DEST_MSB:DEST_LSB];
                if (flag_op && op_overflow)
                begin
                    next_st.ouflag = 1'b1;
                    events[INT_OUFLAG] = 1'b1;
                end
            end
        end

        next_st.int_status = next_st.int_status | events;
        // The interrupt follows the updated status and mask, so it rises
        // on the same edge as the event instead of one cycle later.
        next_st.irq = |(next_st.int_status & next_st.int_mask);

        // Read data is captured when pready is raised and then held, so
        // prdata cannot change while the master samples it.
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (setup_done)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = !addr_known;
            next_st.prdata = (!pwrite && addr_known) ? read_value
                                                     : 32'h0000_0000;
        end
    end

    // ***********************************************************
    // State register
    // ***********************************************************
    // Only constants enter the reset branch, so the asynchronous reset
    // never depends on state that is itself being reset.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= STATE_RESET;
        else
            st <= next_st;
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    // Every output is a field of the state record, so none of them can
    // glitch on a change of the inputs.
    assign result_valid = st.result_valid;
    assign result_data = st.result_data;
    assign result_dest = st.result_dest;
    assign exc_reserved = st.exc_reserved;
    assign exc_dsp_disabled = st.exc_disabled;
    assign ouflag = st.ouflag;
    assign irq = st.irq;
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;

endmodule : fsu_top

// [fsu_top_assertions.sv]
// Concurrent checks on the ports of the fractional subtract unit.
// Assumes the single core_clk domain and the active-low rst_n.
`timescale 1ns/1ps
module fsu_top_assertions
    import fsu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] first_source,
    input wire logic [31:0] second_source,
    input wire logic result_valid,
    input wire logic [31:0] result_data,
    input wire logic [4:0] result_dest,
    input wire logic exc_reserved,
    input wire logic exc_dsp_disabled,
    input wire logic ouflag,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready
);
    // ***********************************************************
    // Reference arithmetic on the issue inputs
    // ***********************************************************
    logic [32:0] wd;
    logic [16:0] hd;
    logic [16:0] ld;
    logic [31:0] wsat;
    logic [10:0] mn;
    logic g, wop, wrp, clp, trn, hlv, pov, wr;
    assign wd = {first_source[31], first_source}
        - {second_source[31], second_source};
    assign hd = {first_source[31], first_source[31:16]}
        - {second_source[31], second_source[31:16]};
    assign ld = {first_source[15], first_source[15:0]}
        - {second_source[15], second_source[15:0]};
    assign wsat = (wd[32] ^ wd[31])
        ? (wd[32] ? 32'h80000000 : 32'h7FFFFFFF) : wd[31:0];
    assign mn = issue_instr[10:0];
    assign g = issue_valid && issue_instr[31:26] == MAJOR_OPCODE_GROUP;
    assign wop = g && mn == {1'b0, MINOR_WORD_CLAMP};
    assign wrp = g && mn == MINOR_PAIR_WRAP;
    assign clp = g && mn == MINOR_PAIR_CLAMP;
    assign trn = g && mn == MINOR_HALVE_TRUNC;
    assign hlv = trn || (g && mn == MINOR_HALVE_ROUND);
    assign pov = (hd[16] ^ hd[15]) | (ld[16] ^ ld[15]);
    // A register write may legally clear the flag, so it is excluded.
    assign wr = psel && penable && pwrite;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ***********************************************************
    // Properties
    // ***********************************************************
    property p_dest;
        result_valid |-> result_dest == $past(issue_instr[15:11]);
    endproperty
    a_dest: assert property (p_dest) else $error("wrong dest");
    property p_wrap;
        result_valid && $past(wrp)
            |-> result_data == $past({hd[15:0], ld[15:0]});
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap data");
    property p_word;
        result_valid && $past(wop) |-> result_data == $past(wsat);
    endproperty
    a_word: assert property (p_word) else $error("word data");
    property p_trunc;
        result_valid && $past(trn)
            |-> result_data == $past({hd[16:1], ld[16:1]});
    endproperty
    a_trunc: assert property (p_trunc) else $error("trunc data");
    property p_pflag;
        result_valid && $past((wrp || clp) && pov) |-> ouflag;
    endproperty
    a_pflag: assert property (p_pflag) else $error("pair flag");
    property p_wflag;
        result_valid && $past(wop && (wd[32] ^ wd[31])) |-> ouflag;
    endproperty
    a_wflag: assert property (p_wflag) else $error("word flag");
    property p_halve;
        $past(hlv && !wr) |-> ouflag == $past(ouflag);
    endproperty
    a_halve: assert property (p_halve) else $error("halve flag");
    property p_fall;
        $fell(ouflag) |-> $past(wr && pready) || $past(wr && pready, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("flag fell");
    property p_exc;
        exc_reserved |-> !result_valid && !exc_dsp_disabled;
    endproperty
    a_exc: assert property (p_exc) else $error("exc overlap");
    property p_noexc;
        issue_valid && wop |=> !exc_reserved;
    endproperty
    a_noexc: assert property (p_noexc) else $error("data exc");
endmodule : fsu_top_assertions

bind fsu_top fsu_top_assertions u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .first_source(first_source),
    .second_source(second_source), .result_valid(result_valid),
    .result_data(result_data), .result_dest(result_dest),
    .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled),
    .ouflag(ouflag), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready)
);

// [test_fractional_subtract_unit.sv]
// Self-checking bench of the fractional subtract unit against a model.
// Assumes the bound checker and APB slave answering after wait states.
`timescale 1ns/1ps
module test_fractional_subtract_unit
    import fsu_pkg::*;
;
    logic core_clk = 0;
    logic rst_n = 0;
    logic issue_valid = 0;
    logic [31:0] issue_instr = 0, first_source = 0, second_source = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0] pstrb = 0;
    logic result_valid, exc_reserved, exc_dsp_disabled, ouflag, irq;
    logic pready, pslverr;
    logic [31:0] result_data, prdata;
    logic [4:0] result_dest;
    int n_fail = 0, checked = 0;
    logic m_fl = 0;
    logic [2:0] m_st = 0, m_mk = 0;
    bit m_ov;
    logic [10:0] mn [5];

    always #2 core_clk = ~core_clk;

    fsu_top dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .first_source(first_source),
        .second_source(second_source), .result_valid(result_valid),
        .result_data(result_data), .result_dest(result_dest),
        .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled),
        .ouflag(ouflag), .irq(irq), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    // ***********************************************************
    // Model, drivers and comparison
    // ***********************************************************
    function automatic logic [31:0] model(input int k, input logic [31:0] a, b);
        longint w;
        int d;
        logic [15:0] r [2];
        m_ov = 0;
        w = longint'($signed(a)) - longint'($signed(b));
        if (k == 2)
        begin
            m_ov = w > 64'sh7FFFFFFF || w < -64'sh80000000;
            return m_ov ? (w < 0 ? 32'h80000000 : 32'h7FFFFFFF) : w[31:0];
        end
        for (int i = 0; i < 2; i++)
        begin
            d = int'($signed(a[16*i+:16])) - int'($signed(b[16*i+:16]));
            if (k < 2 && (d > 32'sh7FFF || d < -32'sh8000))
                m_ov = 1;
            r[i] = d[15:0];
            if (k == 1 && d > 32'sh7FFF)
                r[i] = 16'h7FFF;
            if (k == 1 && d < -32'sh8000)
                r[i] = 16'h8000;
            if (k == 3)
                r[i] = 16'(d >>> 1);
            if (k == 4)
                r[i] = 16'((d + 1) >>> 1);
        end
        return {r[1], r[0]};
    endfunction : model

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
        input logic [3:0] st, output logic [31:0] rd, output logic er);
        int n;
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        pstrb <= st;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(1'b0, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic iss(input logic [31:0] ins, input logic [31:0] a, b);
        @(posedge core_clk);
        issue_valid <= 1;
        issue_instr <= ins;
        first_source <= a;
        second_source <= b;
        @(posedge core_clk);
        issue_valid <= 0;
        #1;
    endtask : iss

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic end_sim();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // ***********************************************************
    // Scenarios
    // ***********************************************************
    initial
    begin
        logic [31:0] a, b, e, r, u;
        logic er;
        mn = '{MINOR_PAIR_WRAP, MINOR_PAIR_CLAMP, {1'b0, MINOR_WORD_CLAMP},
            MINOR_HALVE_TRUNC, MINOR_HALVE_ROUND};
        void'($urandom(77166));
        repeat (6) @(posedge core_clk);
        rst_n <= 1;
        for (int k = 0; k < 4; k++)
        begin
            apb(0, 8'(4 * k), 0, 4'h0, r, er);
            chk(r, k == 0 ? 32'h1 : 32'h0);
        end
        apb(1, ADDR_INT_MASK, 32'h7, 4'h1, r, er);
        m_mk = 3'h7;
        for (int k = 0; k < 5; k++)
            for (int i = 0; i < 40; i++)
            begin
                a = i == 0 ? 32'h80008000 : i == 1 ? 32'h7FFF7FFF : $urandom;
                b = i == 0 ? 32'h7FFF7FFF : i == 1 ? 32'h80008000 : $urandom;
                u = $urandom;
                e = model(k, a, b);
                iss({6'h00, u[14:0], mn[k]}, a, b);
                m_fl |= m_ov;
                m_st[0] |= m_ov;
                chk(result_valid, 1'b1);
                chk(result_data, e);
                chk(result_dest, u[4:0]);
                chk(ouflag, m_fl);
                chk(irq, |(m_st & m_mk));
                // Clearing only every other pass keeps the flag set across ops.
                if (m_fl && i[0])
                begin
                    apb(1, ADDR_DSPCTL, 32'h0, 4'h4, r, er);
                    apb(1, ADDR_INT_STATUS, 32'h7, 4'h1, r, er);
                    m_fl = 0;
                    m_st = 0;
                    settle();
                    chk({ouflag, irq}, 2'b00);
                end
            end
        iss({6'h00, 15'h0, mn[2]}, 32'h80000000, 32'h1);
        apb(0, ADDR_DSPCTL, 0, 4'h0, r, er);
        chk(r, 32'h00100000);
        apb(0, ADDR_RESULT, 0, 4'h0, r, er);
        chk(r, 32'h80000000);
        apb(1, ADDR_INT_MASK, 32'h0, 4'h1, r, er);
        apb(1, ADDR_INT_STATUS, 32'h7, 4'h1, r, er);
        iss(32'h04000000, 32'h1, 32'h2);
        chk({exc_reserved, result_valid, ouflag}, 3'b101);
        settle();
        chk(irq, 1'b0);
        apb(0, ADDR_INT_STATUS, 0, 4'h0, r, er);
        chk(r, 32'h2);
        apb(1, ADDR_INT_MASK, 32'h7, 4'h1, r, er);
        settle();
        chk(irq, 1'b1);
        apb(1, ADDR_INT_STATUS, 32'h2, 4'h1, r, er);
        settle();
        chk(irq, 1'b0);
        apb(1, ADDR_CTRL, 32'h0, 4'h1, r, er);
        iss({6'h00, 15'h0, mn[0]}, 32'h1, 32'h2);
        chk({exc_dsp_disabled, result_valid}, 2'b10);
        apb(0, ADDR_INT_STATUS, 0, 4'h0, r, er);
        chk(r, 32'h4);
        apb(1, ADDR_CTRL, 32'h1, 4'h1, r, er);
        apb(0, 8'h20, 0, 4'h0, r, er);
        chk(er, 1'b1);
        chk(r, 32'h0000_0000);
        end_sim();
    end

    initial
    begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule : test_fractional_subtract_unit
